//--- rtl/pieb_defs.vh
// Summary of operation
// - each request flag sets on its event, whatever the enable bits hold.
// - no peripheral request interrupts without the peripheral group enable set.
// - enable two: osc 7, cmp2 6, cmp1 5, display 4, low voltage 2, capcomp2 0.
// - enable bits: 1 allows, 0 blocks, read/write, reset value zero.
// - bits 3 and 1 of enable two and request two ignore writes, read zero.
// - request one: eeprom, adc, rx, tx, sync port, capcomp1, timer2, timer1.
// - rx flag read-only, set while receive buffer full, clears on data read.
// - tx flag read-only, set while transmit buffer empty, clears on data write.
// - eeprom flag sets when a data memory write completes, sticky.
// - adc flag sets when a conversion completes, sticky.
// - sync port flag sets on transfer complete, cleared only by software.
// - timer two flag sets on period match, sticky.
// - timer one flag sets on counter overflow, sticky.
// - capcomp flags set on capture or compare by mode, unused in pwm mode.
// - request two: osc 7, cmp2 6, cmp1 5, display 4, low voltage 2, capcomp2 0.
// - osc fail flag sets when clock switched to internal oscillator, sticky.
// - comparator flag sets whenever its comparator output changes, sticky.
// - display and low voltage flags set when their modules raise a condition.
`ifndef PIEB_DEFS_VH
`define PIEB_DEFS_VH

// ****************************************
// register byte offsets
// ****************************************
`define PIEB_OFF_ENABLE_TWO   32'h0000_0000
`define PIEB_OFF_REQUEST_ONE  32'h0000_0004
`define PIEB_OFF_REQUEST_TWO  32'h0000_0008
`define PIEB_OFF_MAIN_CTRL    32'h0000_000c
`define PIEB_OFF_ENABLE_ONE   32'h0000_0010

// ****************************************
// field positions
// ****************************************
`define PIEB_BIT_GLOBAL_EN    7
`define PIEB_BIT_GROUP_EN     6
`define PIEB_BIT_RX           5
`define PIEB_BIT_TX           4

// ****************************************
// masks and reset values
// ****************************************
`define PIEB_MASK_TWO         8'hf5
`define PIEB_MASK_ONE_STICKY  8'hcf
`define PIEB_MASK_CTRL        8'hc0
`define PIEB_RESET_BYTE       8'h00
`define PIEB_SYNC_FILL        2'h3  // edges until a synchroniser holds a real pin sample

// ****************************************
// capture/compare modes and bus answers
// ****************************************
`define PIEB_MODE_OFF         2'h0
`define PIEB_MODE_CAPTURE     2'h1
`define PIEB_MODE_COMPARE     2'h2
`define PIEB_MODE_PWM         2'h3
`define PIEB_RESP_OKAY        2'h0
`define PIEB_RESP_SLVERR      2'h2

`endif

//--- rtl/pieb_flag_bank.v
// Design decisions made here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ns
`include "pieb_defs.vh"
`default_nettype none

module pieb_flag_bank (
  clk_sys,
  reset_n,
  s_axi_awaddr,
  s_axi_awvalid,
  s_axi_awready,
  s_axi_wdata,
  s_axi_wstrb,
  s_axi_wvalid,
  s_axi_wready,
  s_axi_bresp,
  s_axi_bvalid,
  s_axi_bready,
  s_axi_araddr,
  s_axi_arvalid,
  s_axi_arready,
  s_axi_rdata,
  s_axi_rresp,
  s_axi_rvalid,
  s_axi_rready,
  eeprom_write_done,
  adc_done,
  serial_rx_full,
  serial_tx_empty,
  sync_port_done,
  capcomp_one_mode,
  capcomp_one_capture,
  capcomp_one_match,
  timer_two_match,
  timer_one_overflow,
  osc_fail,
  comparator_two_output,
  comparator_one_output,
  display_driver_event,
  low_voltage_event,
  capcomp_two_mode,
  capcomp_two_capture,
  capcomp_two_match,
  peripheral_irq
);
  input  wire        clk_sys;
  input  wire        reset_n;
  input  wire [31:0] s_axi_awaddr;
  input  wire        s_axi_awvalid;
  output wire        s_axi_awready;
  input  wire [31:0] s_axi_wdata;
  input  wire [3:0]  s_axi_wstrb;
  input  wire        s_axi_wvalid;
  output wire        s_axi_wready;
  output reg  [1:0]  s_axi_bresp;
  output reg         s_axi_bvalid;
  input  wire        s_axi_bready;
  input  wire [31:0] s_axi_araddr;
  input  wire        s_axi_arvalid;
  output wire        s_axi_arready;
  output reg  [31:0] s_axi_rdata;
  output reg  [1:0]  s_axi_rresp;
  output reg         s_axi_rvalid;
  input  wire        s_axi_rready;
  input  wire        eeprom_write_done;
  input  wire        adc_done;
  input  wire        serial_rx_full;
  input  wire        serial_tx_empty;
  input  wire        sync_port_done;
  input  wire [1:0]  capcomp_one_mode;
  input  wire        capcomp_one_capture;
  input  wire        capcomp_one_match;
  input  wire        timer_two_match;
  input  wire        timer_one_overflow;
  input  wire        osc_fail;
  input  wire        comparator_two_output;
  input  wire        comparator_one_output;
  input  wire        display_driver_event;
  input  wire        low_voltage_event;
  input  wire [1:0]  capcomp_two_mode;
  input  wire        capcomp_two_capture;
  input  wire        capcomp_two_match;
  output reg         peripheral_irq;

  // ****************************************
  // register state
  // ****************************************
  reg  [7:0]  enable_two_reg;
  reg  [7:0]  enable_one_reg;
  reg  [7:0]  main_ctrl_reg;
  reg  [7:0]  request_one_reg;
  reg  [7:0]  request_two_reg;
  reg  [7:0]  enable_two_next;
  reg  [7:0]  enable_one_next;
  reg  [7:0]  main_ctrl_next;
  reg  [7:0]  request_one_next;
  reg  [7:0]  request_two_next;
  reg         aw_held_reg;
  reg         w_held_reg;
  reg  [31:0] wr_addr_reg;
  reg  [7:0]  wr_data_reg;
  reg         wr_lane_reg;
  wire        wr_fire;
  wire        wr_en_two;
  wire        wr_en_one;
  wire        wr_ctrl;
  wire        wr_req_one;
  wire        wr_req_two;
  wire        wr_hit;
  wire [7:0]  req_one_view;
  wire [7:0]  set_one;
  wire [7:0]  set_two;
  wire        capcomp_one_set;
  wire        capcomp_two_set;
  wire [1:0]  cmp_change;
  wire [1:0]  cmp_in;
  reg  [7:0]  rd_byte;
  reg         rd_hit;

  // ****************************************
  // comparator output synchronisers
  // ****************************************
  // comparator outputs come from another domain and pass three stages
  assign cmp_in = {comparator_two_output, comparator_one_output};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_cmp
      reg       s1_reg;
      reg       s2_reg;
      reg       s3_reg;
      reg       stable_reg;
      reg       primed_reg;
      reg [1:0] fill_reg;
      // three stages; the first is read only by the second
      // fill_reg counts the edges the pipe needs to hold a real pin sample,
      // so a level already present at reset is taken as the start level
      always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
          s1_reg     <= 1'b0;
          s2_reg     <= 1'b0;
          s3_reg     <= 1'b0;
          stable_reg <= 1'b0;
          primed_reg <= 1'b0;
          fill_reg   <= 2'h0;
        end else begin
          s1_reg <= cmp_in[gi];
          s2_reg <= s1_reg;
          s3_reg <= s2_reg;
          if (fill_reg != `PIEB_SYNC_FILL) begin
            fill_reg <= fill_reg + 2'h1;
          end
          if (s2_reg == s3_reg) begin
            stable_reg <= s3_reg;
            primed_reg <= (fill_reg == `PIEB_SYNC_FILL);
          end
        end
      end
      // the change pulse lasts one cycle, as stable_reg catches up at the next edge
      // a settled level unlike the last one is a change
      assign cmp_change[gi] = primed_reg & (s2_reg == s3_reg) & (s3_reg != stable_reg);
    end
  endgenerate

  // ****************************************
  // event sources
  // ****************************************
  // capture or compare by mode, nothing in pwm mode
  // off mode sets nothing either, so a parked unit never raises a flag
  assign capcomp_one_set =
    ((capcomp_one_mode == `PIEB_MODE_CAPTURE) & capcomp_one_capture) |
    ((capcomp_one_mode == `PIEB_MODE_COMPARE) & capcomp_one_match);
  assign capcomp_two_set =
    ((capcomp_two_mode == `PIEB_MODE_CAPTURE) & capcomp_two_capture) |
    ((capcomp_two_mode == `PIEB_MODE_COMPARE) & capcomp_two_match);

  // request one sticky sets, rx and tx positions left empty
  // a source held high keeps setting its flag, so a clear sticks only once it drops
  assign set_one = {eeprom_write_done,
                    adc_done,
                    2'b00,
                    sync_port_done,
                    capcomp_one_set,
                    timer_two_match,
                    timer_one_overflow};

  // request two sets in register order
  // unimplemented bits 3 and 1 are tied low here and in the write mask
  assign set_two = {osc_fail,
                    cmp_change[1],
                    cmp_change[0],
                    display_driver_event,
                    1'b0,
                    low_voltage_event,
                    1'b0,
                    capcomp_two_set};

  // rx and tx follow the serial buffers directly
  // not stored: the serial unit drops its level when its data register is read or written
  assign req_one_view = {request_one_reg[7:6],
                         serial_rx_full,
                         serial_tx_empty,
                         request_one_reg[3:0]};

  // ****************************************
  // write channel
  // ****************************************
  // each channel takes one item, then waits for its pair and the response,
  // so a second write cannot overtake the first
  assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_held_reg & ~s_axi_bvalid;
  assign wr_fire       = aw_held_reg & w_held_reg;

  // hold address and data until both are in
  // the response code is fixed when both halves are in
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      aw_held_reg  <= 1'b0;
      w_held_reg   <= 1'b0;
      wr_addr_reg  <= 32'h0000_0000;
      wr_data_reg  <= `PIEB_RESET_BYTE;
      wr_lane_reg  <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `PIEB_RESP_OKAY;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held_reg <= 1'b1;
        wr_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_held_reg  <= 1'b1;
        wr_data_reg <= s_axi_wdata[7:0];
        wr_lane_reg <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_held_reg  <= 1'b0;
        w_held_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `PIEB_RESP_OKAY : `PIEB_RESP_SLVERR;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // address decode of the held write
  // lane 0 carries the only byte; without it a write answers okay and changes nothing
  assign wr_en_two  = wr_fire & wr_lane_reg & (wr_addr_reg == `PIEB_OFF_ENABLE_TWO);
  assign wr_req_one = wr_fire & wr_lane_reg & (wr_addr_reg == `PIEB_OFF_REQUEST_ONE);
  assign wr_req_two = wr_fire & wr_lane_reg & (wr_addr_reg == `PIEB_OFF_REQUEST_TWO);
  assign wr_ctrl    = wr_fire & wr_lane_reg & (wr_addr_reg == `PIEB_OFF_MAIN_CTRL);
  assign wr_en_one  = wr_fire & wr_lane_reg & (wr_addr_reg == `PIEB_OFF_ENABLE_ONE);
  // any other address answers with an error and writes nothing
  assign wr_hit = (wr_addr_reg == `PIEB_OFF_ENABLE_TWO) |
                  (wr_addr_reg == `PIEB_OFF_REQUEST_ONE) |
                  (wr_addr_reg == `PIEB_OFF_REQUEST_TWO) |
                  (wr_addr_reg == `PIEB_OFF_MAIN_CTRL) |
                  (wr_addr_reg == `PIEB_OFF_ENABLE_ONE);

  // ****************************************
  // register next values
  // ****************************************
  // software writes first, hardware sets on top so a set wins
  // a clear that meets an event in the same cycle therefore never loses the event
  always @* begin
    enable_two_next  = enable_two_reg;
    enable_one_next  = enable_one_reg;
    main_ctrl_next   = main_ctrl_reg;
    request_one_next = request_one_reg;
    request_two_next = request_two_reg;
    if (wr_en_two) begin
      enable_two_next = wr_data_reg & `PIEB_MASK_TWO;
    end
    if (wr_en_one) begin
      enable_one_next = wr_data_reg;
    end
    if (wr_ctrl) begin
      main_ctrl_next = wr_data_reg & `PIEB_MASK_CTRL;
    end
    if (wr_req_one) begin
      request_one_next = wr_data_reg & `PIEB_MASK_ONE_STICKY;
    end
    if (wr_req_two) begin
      request_two_next = wr_data_reg & `PIEB_MASK_TWO;
    end
    // flags set regardless of any enable bit
    request_one_next = request_one_next | set_one;
    request_two_next = request_two_next | set_two;
  end

  // register update
  // all five registers start at zero, so nothing is enabled after reset
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      enable_two_reg  <= `PIEB_RESET_BYTE;
      enable_one_reg  <= `PIEB_RESET_BYTE;
      main_ctrl_reg   <= `PIEB_RESET_BYTE;
      request_one_reg <= `PIEB_RESET_BYTE;
      request_two_reg <= `PIEB_RESET_BYTE;
    end else begin
      enable_two_reg  <= enable_two_next;
      enable_one_reg  <= enable_one_next;
      main_ctrl_reg   <= main_ctrl_next;
      request_one_reg <= request_one_next;
      request_two_reg <= request_two_next;
    end
  end

  // ****************************************
  // interrupt request
  // ****************************************
  // any enabled flag, then group and global enables
  // registered so the request never glitches while a flag and its enable change together
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      peripheral_irq <= 1'b0;
    end else begin
      peripheral_irq <= main_ctrl_reg[`PIEB_BIT_GLOBAL_EN] &
                        main_ctrl_reg[`PIEB_BIT_GROUP_EN] &
                        (|((req_one_view & enable_one_reg) |
                           (request_two_reg & enable_two_reg)));
    end
  end

  // ****************************************
  // read channel
  // ****************************************
  assign s_axi_arready = ~s_axi_rvalid;

  // read decode, unused bits return zero
  always @* begin
    rd_byte = `PIEB_RESET_BYTE;
    rd_hit  = 1'b1;
    case (s_axi_araddr)
      `PIEB_OFF_ENABLE_TWO: begin
        rd_byte = enable_two_reg;
      end
      `PIEB_OFF_REQUEST_ONE: begin
        rd_byte = req_one_view;
      end
      `PIEB_OFF_REQUEST_TWO: begin
        rd_byte = request_two_reg;
      end
      `PIEB_OFF_MAIN_CTRL: begin
        rd_byte = main_ctrl_reg;
      end
      `PIEB_OFF_ENABLE_ONE: begin
        rd_byte = enable_one_reg;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // read answer held until taken
  // the byte is captured with the address; a flag set after that shows on the next read
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `PIEB_RESP_OKAY;
    end else begin
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h00_0000, rd_byte};
        s_axi_rresp  <= rd_hit ? `PIEB_RESP_OKAY : `PIEB_RESP_SLVERR;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // pieb_flag_bank

`default_nettype wire

//--- tb/pieb_flag_chk.sv
`timescale 1ns/1ns
`default_nettype none
// ****
// bus handshake checks
// ****
module pieb_flag_chk (
  input wire logic        clk_sys,
  input wire logic        reset_n,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped early");
  a_b_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  a_r_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  a_r_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer open");
  a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer open");
  a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_b_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:3] s_axi_bvalid) else $error("write not answered");
endmodule // pieb_flag_chk
`default_nettype wire

//--- tb/pieb_src_model.sv
`timescale 1ns/1ns
`default_nettype none
// ****
// peripheral event sources
// ****
module pieb_src_model (
  input wire logic        clk_sys,
  input wire logic        reset_n,
  input wire logic [15:0] ev,
  input wire logic        pick,
  output logic [17:0]     src
);
  logic c1, c2;
  // comparator outputs toggle on request
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) {c2, c1} <= 2'h0;
    else {c2, c1} <= {c2, c1} ^ ev[14:13];
  end
  // pick steers capture or match pulses
  assign src = {ev[8] & !pick, ev[2] & !pick, ev[15], c2, c1, ev[12:9], ev[8] & pick, ev[7:3], ev[2] & pick, ev[1:0]};
endmodule // pieb_src_model
`default_nettype wire

//--- tb/test_peripheral_irq_enable_flag_bank.sv
`timescale 1ns/1ns
`include "pieb_defs.vh"
`default_nettype none
module test_peripheral_irq_enable_flag_bank;
  logic        clk_sys = 1'b0, reset_n = 1'b0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, pick = 0;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0;
  logic [1:0]  lv = '0, m1 = '0, m2 = '0, r;
  logic [3:0]  strb = 4'h1;
  logic [15:0] ev = '0, rnd = 16'h0048;
  logic [7:0]  f1 = '0, f2 = '0, e1, e2, ct, q;
  logic [31:0] adr [0:4] = '{`PIEB_OFF_ENABLE_TWO, `PIEB_OFF_REQUEST_ONE, `PIEB_OFF_REQUEST_TWO,
                             `PIEB_OFF_MAIN_CTRL, `PIEB_OFF_ENABLE_ONE};
  wire logic        awready, wready, bvalid, arready, rvalid, irq;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [17:0] src;
  integer      err_count = 0, checks = 0, i;
  // ****
  // clock, sources, design
  // ****
  always #50 clk_sys = ~clk_sys;
  pieb_src_model u_src (.clk_sys(clk_sys), .reset_n(reset_n), .ev(ev), .pick(pick), .src(src));
  pieb_flag_bank uut (.clk_sys(clk_sys), .reset_n(reset_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .eeprom_write_done(src[7]), .adc_done(src[6]),
    .serial_rx_full(lv[1]), .serial_tx_empty(lv[0]), .sync_port_done(src[3]), .capcomp_one_mode(m1),
    .capcomp_one_capture(src[2]), .capcomp_one_match(src[16]), .timer_two_match(src[1]),
    .timer_one_overflow(src[0]), .osc_fail(src[15]), .comparator_two_output(src[14]),
    .comparator_one_output(src[13]), .display_driver_event(src[12]), .low_voltage_event(src[10]),
    .capcomp_two_mode(m2), .capcomp_two_capture(src[8]), .capcomp_two_match(src[17]), .peripheral_irq(irq));
  // ****
  // helpers
  // ****
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // one bus transfer, handshakes judged at the falling edge before each rising edge
  task automatic bus(input logic w, input logic [31:0] a, input logic [7:0] d, output logic [7:0] qo,
                     output logic [1:0] ro);
    logic ta, tw, tr, done;
    integer n;
    n = 0;
    done = 0;
    awaddr <= a;
    araddr <= a;
    wdata <= {24'h0, d};
    awvalid <= w;
    wvalid <= w;
    arvalid <= !w;
    while (!done && n < 64) begin
      @(negedge clk_sys);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tr = arvalid & arready;
      done = w ? bvalid : rvalid;
      @(posedge clk_sys);
      if (ta) awvalid <= 0;
      if (tw) wvalid <= 0;
      if (tr) arvalid <= 0;
      n++;
    end
    bready <= w;
    rready <= !w;
    // the answer stands until the ready edge, so take it just before that edge
    @(negedge clk_sys);
    qo = rdata[7:0];
    ro = w ? bresp : rresp;
    @(posedge clk_sys);
    bready <= 0;
    rready <= 0;
    if (!done) begin
      err_count++;
      stop_test();
    end
  endtask
  // ****
  // main sequence
  // ****
  initial begin
    repeat (20) @(posedge clk_sys);
    reset_n <= 1;
    @(posedge clk_sys);
    for (i = 0; i < 5; i++) begin
      bus(0, adr[i], 8'h00, q, r);
      chk(q, 8'h00, "reset value");
    end
    bus(1, 32'h14, 8'hff, q, r);
    chk({6'h0, r}, {6'h0, `PIEB_RESP_SLVERR}, "unmapped write");
    bus(0, 32'h14, 8'h00, q, r);
    chk({6'h0, r}, {6'h0, `PIEB_RESP_SLVERR}, "unmapped read");
    strb <= 4'h0;
    bus(1, adr[0], 8'hff, q, r);
    chk({6'h0, r}, {6'h0, `PIEB_RESP_OKAY}, "lane off write");
    strb <= 4'h1;
    bus(0, adr[0], 8'h00, q, r);
    chk(q, 8'h00, "lane off kept");
    for (i = 0; i < 24; i++) begin
      rnd = lfsr(rnd);
      @(posedge clk_sys);
      ev <= rnd;
      pick <= rnd[11];
      m1 <= rnd[5:4];
      m2 <= rnd[13:12];
      lv <= rnd[9:8];
      @(posedge clk_sys);
      ev <= '0;
      f1 = f1 | (rnd[7:0] & 8'hcb) | {5'h0, rnd[2] & ((m1 == `PIEB_MODE_CAPTURE && pick)
           || (m1 == `PIEB_MODE_COMPARE && !pick)), 2'h0};
      f2 = f2 | (rnd[15:8] & 8'hf4) | {7'h0, rnd[8] & ((m2 == `PIEB_MODE_CAPTURE && pick)
           || (m2 == `PIEB_MODE_COMPARE && !pick))};
      repeat (8) @(posedge clk_sys);
      bus(0, adr[1], 8'h00, q, r);
      chk(q, f1 | {2'h0, lv, 4'h0}, "request one");
      bus(0, adr[2], 8'h00, q, r);
      chk(q, f2, "request two");
      e2 = rnd[7:0] ^ rnd[15:8];
      e1 = rnd[15:8];
      ct = {rnd[0] | i[0], rnd[6] | i[0], rnd[5:0]};
      bus(1, adr[0], e2, q, r);
      chk({6'h0, r}, {6'h0, `PIEB_RESP_OKAY}, "write answer");
      bus(0, adr[0], 8'h00, q, r);
      chk(q, e2 & 8'hf5, "enable two");
      bus(1, adr[4], e1, q, r);
      bus(1, adr[3], ct, q, r);
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys);
      chk({7'h0, irq}, {7'h0, ct[7] & ct[6] & |(((f1 | {2'h0, lv, 4'h0}) & e1) | (f2 & e2 & 8'hf5))}, "irq");
      // write new flag values from rnd before the next enable round
      bus(1, adr[1], rnd[15:8], q, r);
      f1 = rnd[15:8] & 8'hcf;
      bus(1, adr[2], rnd[7:0], q, r);
      f2 = rnd[7:0] & 8'hf5;
    end
    stop_test();
  end
endmodule // test_peripheral_irq_enable_flag_bank
bind pieb_flag_bank pieb_flag_chk u_chk (.clk_sys(clk_sys), .reset_n(reset_n), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
`default_nettype wire
